// ==== design/e3_rx_error_monitor.sv ====
// Receive E3 (G.832) error monitor: EM/BIP-8, FEBE and FA1/FA2 checks,
// performance counters, one-second parity accumulator, interrupts.
// Assumes a byte stream aligned by an upstream framer with a start strobe on
// FA1, synchronous to clock_i, and an AXI4-Lite master for the registers.
//
// Function
// - Each erred EM byte adds one to the 16-bit parity error counter.
// - Each erred EM byte also adds one to the read-only one-second accumulator.
// - Each erred EM byte makes the transmit framer send REI set to one.
// - Received REI one sets interrupt status bit 4 and asserts the interrupt.
// - Each received REI one adds one to the 16-bit far-end error counter.
// - In frame maintenance, every frame's FA1 and FA2 bytes are checked.
// - FA errors in four consecutive frames enter out-of-frame and declare OOF.
// - An FA1 or FA2 error in frame maintenance sets interrupt status bit 1 and asserts interrupt.
// - BIP-8 of a frame is compared with next EM; mismatch sets bit 2.
// - Each frame with FA errors adds one to the framing error counter.
// - Performance counters hold while OOF or LOF is declared.
`timescale 1ns/10ps
`default_nettype none

module e3_rx_error_monitor #(
  parameter int SECOND_CYCLES_P = e3_rx_error_monitor_pkg::SECOND_CYCLES
) (
  input  wire logic                                      clock_i,
  input  wire logic                                      nrst_i,
  input  wire logic [7:0]                                rx_byte_i,
  input  wire logic                                      rx_valid_i,
  input  wire logic                                      rx_frame_start_i,
  input  wire logic                                      lof_defect_i,
  input  wire logic [e3_rx_error_monitor_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                                      s_axi_awvalid_i,
  output logic                                           s_axi_awready_o,
  input  wire logic [e3_rx_error_monitor_pkg::DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                                s_axi_wstrb_i,
  input  wire logic                                      s_axi_wvalid_i,
  output logic                                           s_axi_wready_o,
  output logic [1:0]                                     s_axi_bresp_o,
  output logic                                           s_axi_bvalid_o,
  input  wire logic                                      s_axi_bready_i,
  input  wire logic [e3_rx_error_monitor_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                                      s_axi_arvalid_i,
  output logic                                           s_axi_arready_o,
  output logic [e3_rx_error_monitor_pkg::DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]                                     s_axi_rresp_o,
  output logic                                           s_axi_rvalid_o,
  input  wire logic                                      s_axi_rready_i,
  output logic                                           irq_n_o,
  output logic                                           oof_defect_o,
  output logic                                           tx_febe_insert_o
);
  import e3_rx_error_monitor_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_n_meta;
  logic rst_n;

  // Async assert, two-flop release so no flop leaves reset on a ragged edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_n_meta <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_n_meta <= 1'b1;
      rst_n      <= rst_n_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Frame position and per-frame checks
  // ----------------------------------------------------------------------
  frame_state_t frame_state;
  logic [9:0]   pos;
  logic [9:0]   next_pos;
  logic         fa1_bad;
  logic [7:0]   bip_acc;
  logic [7:0]   bip_prev;
  logic         bip_have;
  logic         frame_seen;
  logic [2:0]   fa_err_run;
  logic         fa_check;
  logic         frame_fa_bad;
  logic         fa_evt;
  logic         bip_evt;
  logic         febe_evt;
  logic         pm_halt;

  // Upstream aligner marks FA1; position runs free between strobes
  assign next_pos     = rx_frame_start_i ? POS_FA1 : pos + 10'h001;
  assign fa_check     = rx_valid_i && (next_pos == POS_FA2);
  assign frame_fa_bad = fa1_bad || (rx_byte_i != FA2_VALUE);
  assign fa_evt       = fa_check && frame_fa_bad && (frame_state == IN_FRAME);
  // No BIP judgement until one whole frame has been summed
  assign bip_evt      = rx_valid_i && (next_pos == POS_EM) && bip_have
                        && (rx_byte_i != bip_prev);
  assign febe_evt     = rx_valid_i && (next_pos == POS_MA) && rx_byte_i[MA_REI_BIT];
  assign pm_halt      = (frame_state == OUT_OF_FRAME) || lof_defect_i;

  // Byte position, FA1 check and BIP-8 over the whole frame
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pos        <= POS_FA1;
      fa1_bad    <= 1'b0;
      bip_acc    <= 8'h00;
      bip_prev   <= 8'h00;
      bip_have   <= 1'b0;
      frame_seen <= 1'b0;
    end else if (rx_valid_i) begin
      pos <= next_pos;
      if (next_pos == POS_FA1) begin
        fa1_bad <= (rx_byte_i != FA1_VALUE);
      end
      if (rx_frame_start_i) begin
        bip_prev   <= bip_acc;
        bip_acc    <= rx_byte_i;
        bip_have   <= frame_seen;
        frame_seen <= 1'b1;
      end else begin
        bip_acc <= bip_acc ^ rx_byte_i;
      end
    end
  end

  // Frame maintenance versus out-of-frame; a clean FA pair restores frame
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_state <= IN_FRAME;
      fa_err_run  <= 3'h0;
    end else if (fa_check) begin
      unique case (frame_state)
        IN_FRAME: begin
          if (!frame_fa_bad) begin
            fa_err_run <= 3'h0;
          end else if (fa_err_run + 3'h1 == OOF_ERR_FRAMES) begin
            frame_state <= OUT_OF_FRAME;
            fa_err_run  <= 3'h0;
          end else begin
            fa_err_run <= fa_err_run + 3'h1;
          end
        end
        OUT_OF_FRAME: begin
          if (!frame_fa_bad) begin
            frame_state <= IN_FRAME;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register bus: write and read channels
  // ----------------------------------------------------------------------
  logic [IDX_W-1:0]  aw_idx;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              do_write;
  logic              ar_take;
  logic [IDX_W-1:0]  ar_idx;
  logic [DATA_W-1:0] rd_word;
  logic              rd_mapped;
  logic              wr_mapped;
  logic [7:0]        int_status;
  logic [7:0]        int_enable;
  logic [7:0]        int_clear;
  logic [15:0]       pm_count [NUM_PM];
  logic [15:0]       accum_run;
  logic [15:0]       accum_snap;

  // Both halves held, response slot free: commit exactly once
  assign do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign ar_take  = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_idx   = s_axi_araddr_i[ADDR_W-1:2];
  assign wr_mapped = (aw_idx == IDX_INT_STATUS_TWO) || (aw_idx == IDX_INT_ENABLE_TWO);
  assign int_clear = (do_write && w_lane0 && aw_idx == IDX_INT_STATUS_TWO) ? (w_byte & INT_IMPL_MASK) : 8'h00;

  // Address and data are taken independently, in either order
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      aw_idx          <= '0;
      w_byte          <= 8'h00;
      w_lane0         <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
        aw_idx          <= s_axi_awaddr_i[ADDR_W-1:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
        w_byte         <= s_axi_wdata_i[7:0];
        w_lane0        <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read data select; narrow registers sit in the low byte
  always_comb begin
    rd_word   = '0;
    rd_mapped = 1'b1;
    unique case (ar_idx)
      IDX_CONFIG_STATUS_TWO: begin
        rd_word[STATUS_LOF_BIT] = lof_defect_i;
        rd_word[STATUS_OOF_BIT] = (frame_state == OUT_OF_FRAME);
      end
      IDX_INT_STATUS_TWO: rd_word[7:0] = int_status;
      IDX_INT_ENABLE_TWO: rd_word[7:0] = int_enable;
      IDX_ACCUM_HIGH:     rd_word[7:0] = accum_snap[15:8];
      IDX_ACCUM_LOW:      rd_word[7:0] = accum_snap[7:0];
      default:            rd_mapped = 1'b0;
    endcase
    for (int k = 0; k < NUM_PM; k++) begin
      if (ar_idx == PM_HIGH_IDX[k]) begin
        rd_word[7:0] = pm_count[k][15:8];
        rd_mapped    = 1'b1;
      end
      if (ar_idx == PM_LOW_IDX[k]) begin
        rd_word[7:0] = pm_count[k][7:0];
        rd_mapped    = 1'b1;
      end
    end
  end

  // Read channel: one read outstanding, data latched at address accept
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Performance counters, clear on read, saturating
  // ----------------------------------------------------------------------
  logic [NUM_PM-1:0] pm_inc;

  assign pm_inc[PM_FRAMING] = fa_evt && !pm_halt;
  assign pm_inc[PM_PARITY]  = bip_evt && !pm_halt;
  assign pm_inc[PM_FAR_END] = febe_evt && !pm_halt;

  for (genvar g = 0; g < NUM_PM; g++) begin : g_pm
    logic [15:0] cleared;

    // The read returns the old byte; an increment in the same cycle survives
    always_comb begin
      cleared = pm_count[g];
      if (ar_take && ar_idx == PM_HIGH_IDX[g]) begin
        cleared[15:8] = 8'h00;
      end
      if (ar_take && ar_idx == PM_LOW_IDX[g]) begin
        cleared[7:0] = 8'h00;
      end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        pm_count[g] <= COUNT_RESET;
      end else if (pm_inc[g] && cleared != COUNT_MAX) begin
        pm_count[g] <= cleared + 16'h0001;
      end else begin
        pm_count[g] <= cleared;
      end
    end
  end

  // ----------------------------------------------------------------------
  // One-second parity accumulator
  // ----------------------------------------------------------------------
  logic [31:0] second_cnt;
  logic        second_tick;

  assign second_tick = (second_cnt == 32'(SECOND_CYCLES_P - 1));

  // Snapshot each second so software sees a stable whole-second figure
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      second_cnt <= 32'h0000_0000;
      accum_run  <= COUNT_RESET;
      accum_snap <= COUNT_RESET;
    end else begin
      second_cnt <= second_tick ? 32'h0000_0000 : second_cnt + 32'h0000_0001;
      if (second_tick) begin
        accum_snap <= (bip_evt && accum_run != COUNT_MAX) ? accum_run + 16'h0001 : accum_run;
        accum_run  <= COUNT_RESET;
      end else if (bip_evt && accum_run != COUNT_MAX) begin
        accum_run <= accum_run + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts and outputs
  // ----------------------------------------------------------------------
  logic [7:0] int_set;

  always_comb begin
    int_set                  = 8'h00;
    int_set[INT_FEBE_BIT]    = febe_evt;
    int_set[INT_BIP_BIT]     = bip_evt;
    int_set[INT_FRAMING_BIT] = fa_evt;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= INT_STATUS_RESET;
    end else begin
      int_status <= (int_status & ~int_clear) | int_set;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      int_enable <= INT_ENABLE_RESET;
    end else if (do_write && w_lane0 && aw_idx == IDX_INT_ENABLE_TWO) begin
      int_enable <= w_byte & INT_IMPL_MASK;
    end
  end

  // Registered pins; interrupt lags the status bit by one cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_o          <= 1'b1;
      oof_defect_o     <= 1'b0;
      tx_febe_insert_o <= 1'b0;
    end else begin
      irq_n_o          <= ~|(int_status & int_enable);
      oof_defect_o     <= (frame_state == OUT_OF_FRAME);
      tx_febe_insert_o <= bip_evt;
    end
  end

endmodule

`default_nettype wire

// ==== design/e3_rx_error_monitor_pkg.sv ====
// Constants for the E3 G.832 receive error monitor: register map, field
// layout, frame layout, timing and bus response codes.
// Assumes a single 200 MHz clock domain and a 32-bit AXI4-Lite register bus.
package e3_rx_error_monitor_pkg;

  // ----------------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W = 16;
  localparam int          DATA_W = 32;
  localparam int          IDX_W  = 14;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CONFIG_STATUS_TWO = 14'h1111;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS_TWO    = 14'h1115;
  localparam logic [IDX_W-1:0] IDX_INT_ENABLE_TWO    = 14'h1116;
  localparam logic [IDX_W-1:0] IDX_ACCUM_HIGH        = 14'h1170;
  localparam logic [IDX_W-1:0] IDX_ACCUM_LOW         = 14'h1171;

  // Performance counters: framing, parity, far-end, each high then low
  localparam int NUM_PM     = 3;
  localparam int PM_FRAMING = 0;
  localparam int PM_PARITY  = 1;
  localparam int PM_FAR_END = 2;
  localparam logic [IDX_W-1:0] PM_HIGH_IDX [NUM_PM] = '{14'h1152, 14'h1154, 14'h1156};
  localparam logic [IDX_W-1:0] PM_LOW_IDX  [NUM_PM] = '{14'h1153, 14'h1155, 14'h1157};

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int         INT_FEBE_BIT     = 4;
  localparam int         INT_BIP_BIT      = 2;
  localparam int         INT_FRAMING_BIT  = 1;
  localparam logic [7:0] INT_IMPL_MASK    = 8'h16;
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam int         STATUS_LOF_BIT   = 6;
  localparam int         STATUS_OOF_BIT   = 5;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------------
  // G.832 frame layout (byte positions counted from FA1)
  // ----------------------------------------------------------------------
  localparam logic [9:0] POS_FA1     = 10'h000;
  localparam logic [9:0] POS_FA2     = 10'h001;
  localparam logic [9:0] POS_EM      = 10'h03C;
  localparam logic [9:0] POS_MA      = 10'h0B4;
  localparam logic [7:0] FA1_VALUE   = 8'hF6;
  localparam logic [7:0] FA2_VALUE   = 8'h28;
  localparam int         MA_REI_BIT  = 6;
  localparam logic [2:0] OOF_ERR_FRAMES = 3'h4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_MHZ     = 200;
  localparam int ONE_SECOND_MS = 1000;
  localparam int SECOND_CYCLES = ONE_SECOND_MS * 1000 * CLOCK_MHZ;

  typedef enum logic {IN_FRAME, OUT_OF_FRAME} frame_state_t;

endpackage

// ==== sim/e3_far_end_model.sv ====
// Far-end E3 terminal: sends G.832 frames with a true EM byte.
// The bench calls send_frame; bytes move right after rising edges.
`timescale 1ns/10ps
`default_nettype none
module e3_far_end_model
  import e3_rx_error_monitor_pkg::*;
#(
  parameter int FRAME_LEN = 200
) (
  input  wire logic       clock_i,
  output logic [7:0]      byte_o,
  output logic            valid_o,
  output logic            start_o
);
  // ----------------------------------------
  // Frame source
  // ----------------------------------------
  logic [7:0] bip = 8'h00;
  initial begin
    byte_o = 8'h00;
    valid_o = 1'b0;
    start_o = 1'b0;
  end
  // Faults only where the bench asks; BIP covers the whole frame
  task automatic send_frame(input logic bad_fa, input logic bad_em, input logic rei);
    logic [7:0] b;
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < FRAME_LEN; i++) begin
      b = 8'(i * 7 + 3);
      if (i == int'(POS_FA1)) b = bad_fa ? ~FA1_VALUE : FA1_VALUE;
      if (i == int'(POS_FA2)) b = FA2_VALUE;
      if (i == int'(POS_EM)) b = bad_em ? ~bip : bip;
      if (i == int'(POS_MA)) b[MA_REI_BIT] = rei;
      @(posedge clock_i);
      byte_o <= b;
      valid_o <= 1'b1;
      start_o <= (i == 0);
      acc = acc ^ b;
    end
    bip = acc;
    // Released data line shows the inverse, never a stale byte
    @(posedge clock_i);
    valid_o <= 1'b0;
    start_o <= 1'b0;
    byte_o <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== sim/e3_rx_error_monitor_properties.sv ====
// Concurrent checks on the ports of the E3 receive error monitor.
// Bound to the monitor from the bench file; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module e3_rx_error_monitor_properties
  import e3_rx_error_monitor_pkg::*;
(
  input wire logic       clock_i, nrst_i, rx_valid_i, rx_frame_start_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic       s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
  input wire logic       s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic       s_axi_rvalid_o, s_axi_rready_i, irq_n_o, oof_defect_o, tx_febe_insert_o
);
  // ----------------------------------------
  // Shadow of position, BIP-8 and framing run
  // ----------------------------------------
  logic [9:0] pos_q, pos;
  logic [7:0] acc_q, bip_q, fa1_q;
  logic [1:0] starts_q;
  logic [2:0] run_q;
  logic       em_bad, fa_chk, fa_bad, oof_trig;
  assign pos      = rx_frame_start_i ? POS_FA1 : pos_q + 10'h001;
  assign em_bad   = rx_valid_i && pos == POS_EM && starts_q == 2'h2 && rx_byte_i != bip_q;
  assign fa_chk   = rx_valid_i && pos == POS_FA2;
  assign fa_bad   = fa1_q != FA1_VALUE || rx_byte_i != FA2_VALUE;
  assign oof_trig = fa_chk && fa_bad && run_q == 3'h3;
  // Idle cycles leave the shadow alone, as in the monitor
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos_q <= 10'h000;
      acc_q <= 8'h00;
      bip_q <= 8'h00;
      fa1_q <= 8'h00;
      starts_q <= 2'h0;
      run_q <= 3'h0;
    end else if (rx_valid_i) begin
      pos_q <= pos;
      acc_q <= rx_frame_start_i ? rx_byte_i : acc_q ^ rx_byte_i;
      if (rx_frame_start_i) bip_q <= acc_q;
      if (rx_frame_start_i && starts_q != 2'h2) starts_q <= starts_q + 2'h1;
      if (pos == POS_FA1) fa1_q <= rx_byte_i;
      if (fa_chk) run_q <= !fa_bad ? 3'h0 : (run_q == 3'h4 ? run_q : run_q + 3'h1);
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  chk_febe_on_error:
    assert property (em_bad |=> tx_febe_insert_o) else $error("no REI request after bad EM");
  chk_febe_cause:
    assert property (tx_febe_insert_o |-> $past(em_bad)) else $error("REI request without bad EM");
  chk_oof_entry:
    assert property (oof_trig && !oof_defect_o |=> ##1 oof_defect_o) else $error("OOF not declared");
  chk_oof_cause:
    assert property ($rose(oof_defect_o) |-> $past(oof_trig, 2)) else $error("OOF without run");
  chk_oof_leave:
    assert property (fa_chk && !fa_bad && oof_defect_o |=> ##1 !oof_defect_o) else $error("OOF kept");
  chk_irq_release:
    assert property ($rose(irq_n_o) |-> $past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2))
      else $error("interrupt released without a write");
  chk_write_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write answer late");
  chk_read_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer late");
  chk_r_release:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
      else $error("read channel not released");
endmodule
`default_nettype wire

// ==== sim/test_e3_rx_error_monitor.sv ====
// Self-checking bench for the E3 receive error monitor.
// Frames come from the far-end model, registers over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_e3_rx_error_monitor;
  import e3_rx_error_monitor_pkg::*;
  // ----------------------------------------
  // Signals, clock, instances
  // ----------------------------------------
  logic        clock_i = 1'b0, nrst_i = 1'b0, lof = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq_n, oof, febe_ins, rx_valid, rx_start;
  logic [7:0]  rx_byte;
  int          errors = 0, compares = 0, pulses = 0;
  always #2.5 clock_i = ~clock_i;
  // Count transmit REI requests; each stands one cycle
  always @(posedge clock_i) if (febe_ins === 1'b1) pulses++;
  e3_far_end_model e3_far_end_model_inst (.clock_i(clock_i), .byte_o(rx_byte), .valid_o(rx_valid),
    .start_o(rx_start));
  e3_rx_error_monitor #(.SECOND_CYCLES_P(1000)) e3_rx_error_monitor_inst (.clock_i(clock_i),
    .nrst_i(nrst_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_frame_start_i(rx_start),
    .lof_defect_i(lof), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_n_o(irq_n), .oof_defect_o(oof),
    .tx_febe_insert_o(febe_ins));
  // ----------------------------------------
  // Bus and frame tasks
  // ----------------------------------------
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge clock_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic expect_reg(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    `CHK(d, {24'h00_0000, e})
    `CHK(r, RESP_OKAY)
  endtask
  task automatic tx(input logic fa, input logic em, input logic rei);
    e3_far_end_model_inst.send_frame(fa, em, rei);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic check_map();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < NUM_PM; i++) begin
      expect_reg(PM_HIGH_IDX[i], 8'h00);
      expect_reg(PM_LOW_IDX[i], 8'h00);
    end
    expect_reg(IDX_ACCUM_LOW, 8'h00);
    expect_reg(IDX_INT_STATUS_TWO, INT_STATUS_RESET);
    rd(14'h0000, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    wr(IDX_ACCUM_HIGH, 8'h5A, r);
    `CHK(r, RESP_SLVERR)
    wr(IDX_INT_ENABLE_TWO, INT_IMPL_MASK, r);
    `CHK(irq_n, 1'b1)
  endtask
  task automatic check_bip_febe();
    logic [1:0] r;
    int         n;
    n = pulses;
    tx(1'b0, 1'b1, 1'b0);
    `CHK(pulses, n + 1)
    `CHK(irq_n, 1'b0)
    expect_reg(IDX_INT_STATUS_TWO, 8'h04);
    expect_reg(PM_HIGH_IDX[PM_PARITY], 8'h00);
    expect_reg(PM_LOW_IDX[PM_PARITY], 8'h01);
    expect_reg(PM_LOW_IDX[PM_PARITY], 8'h00);
    wr(IDX_INT_STATUS_TWO, 8'h04, r);
    repeat (2) @(posedge clock_i);
    `CHK(irq_n, 1'b1)
    tx(1'b0, 1'b0, 1'b1);
    tx(1'b0, 1'b0, 1'b1);
    `CHK(irq_n, 1'b0)
    expect_reg(IDX_INT_STATUS_TWO, 8'h10);
    expect_reg(PM_LOW_IDX[PM_FAR_END], 8'h02);
    tx(1'b0, 1'b0, 1'b0);
    expect_reg(PM_LOW_IDX[PM_FAR_END], 8'h00);
    wr(IDX_INT_STATUS_TWO, 8'h10, r);
  endtask
  task automatic check_framing();
    logic [1:0]  r;
    wr(IDX_INT_ENABLE_TWO, 8'h00, r);
    tx(1'b1, 1'b0, 1'b0);
    `CHK(irq_n, 1'b1)
    expect_reg(IDX_INT_STATUS_TWO, 8'h02);
    expect_reg(PM_LOW_IDX[PM_FRAMING], 8'h01);
    wr(IDX_INT_ENABLE_TWO, INT_IMPL_MASK, r);
    tx(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) tx(1'b1, 1'b0, 1'b0);
    `CHK(oof, 1'b0)
    tx(1'b1, 1'b0, 1'b0);
    `CHK(oof, 1'b1)
    expect_reg(IDX_CONFIG_STATUS_TWO, 8'h20);
    expect_reg(PM_HIGH_IDX[PM_FRAMING], 8'h00);
    expect_reg(PM_LOW_IDX[PM_FRAMING], 8'h04);
    tx(1'b1, 1'b0, 1'b1);
    expect_reg(PM_LOW_IDX[PM_FAR_END], 8'h00);
    expect_reg(PM_LOW_IDX[PM_FRAMING], 8'h00);
    tx(1'b0, 1'b0, 1'b0);
    `CHK(oof, 1'b0)
    lof <= 1'b1;
    tx(1'b0, 1'b0, 1'b1);
    expect_reg(IDX_CONFIG_STATUS_TWO, 8'h40);
    expect_reg(PM_LOW_IDX[PM_FAR_END], 8'h00);
    lof <= 1'b0;
    wr(IDX_INT_STATUS_TWO, INT_IMPL_MASK, r);
  endtask
  task automatic check_accum();
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0000_0000;
    tx(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 30 && d[7:0] !== 8'h01; i++) begin
      repeat (100) @(posedge clock_i);
      rd(IDX_ACCUM_LOW, d, r);
    end
    `CHK(d, 32'h0000_0001)
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: two good frames first so the EM check is armed
  initial begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    tx(1'b0, 1'b0, 1'b0);
    tx(1'b0, 1'b0, 1'b0);
    check_map();
    check_bip_febe();
    check_framing();
    check_accum();
    give_verdict();
  end
  // Watchdog: the run needs about a fifteenth of this
  initial begin
    repeat (60000) @(posedge clock_i);
    errors++;
    give_verdict();
  end
endmodule
bind e3_rx_error_monitor e3_rx_error_monitor_properties e3_rx_error_monitor_properties_inst (.*);
`default_nettype wire
